//--- core/mau_bank_reg.v
// One register of the unit held twice, a primary and an alternate copy.
// Assumes the bank select is a same-clock level from the mode logic.
`default_nettype none

module mau_bank_reg #(
   parameter W = 16
) (
   input wire clk,
   input wire nrst,
   input wire bankSel,
   input wire wrEn,
   input wire [W-1:0] wrData,
   output wire [W-1:0] rdData
);

   reg [W-1:0] primary_ff;
   reg [W-1:0] alternate_ff;

   // ****************************************
   // Storage of both copies
   // ****************************************
   // only the active copy changes
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         primary_ff <= {W{1'b0}};
         alternate_ff <= {W{1'b0}};
      end else if (wrEn) begin
         if (bankSel) begin
            alternate_ff <= wrData;
         end else begin
            primary_ff <= wrData;
         end
      end
   end

   assign rdData = bankSel ? alternate_ff : primary_ff;

endmodule

`default_nettype wire

//--- core/mau_core.v
// Multiply/accumulate unit: 16x16 multiplier, 40-bit adder/subtractor,
// operand, feedback and accumulator registers in two banks.
// Assumes decoder, data buses and mode bit all run on core_clk, so no
// input is synchronised; at most one data-bus write per cycle.
`default_nettype none
`include "mau_defs.vh"

module mau_core (
   input wire core_clk,
   input wire nrst,
   input wire bankSelect,
   input wire opValid,
   input wire [1:0] opFunc,
   input wire xSigned,
   input wire ySigned,
   input wire [2:0] xSel,
   input wire [1:0] ySel,
   input wire opDest,
   input wire [15:0] aluResult,
   input wire [15:0] shifterResultLow,
   input wire [15:0] shifterResultHigh,
   input wire dmdWrEn,
   input wire [2:0] dmdWrSel,
   input wire [15:0] dmdWrData,
   input wire dmdRdEn,
   input wire [2:0] dmdRdSel,
   input wire pmdWrEn,
   input wire pmdWrSel,
   input wire [15:0] pmdWrData,
   input wire rBusRdEn,
   input wire [1:0] rBusSel,
   input wire statusWrEn,
   input wire statusWrData,
   output reg [15:0] dmdRdData_ff,
   output reg [15:0] rBusData_ff,
   output reg accumOverflow_ff
);

   // ****************************************
   // Register file outputs
   // ****************************************
   wire [15:0] xOp0Q;
   wire [15:0] xOp1Q;
   wire [15:0] yOp0Q;
   wire [15:0] yOp1Q;
   wire [15:0] fbkQ;
   wire [15:0] resLowQ;
   wire [15:0] resMidQ;
   wire [7:0] resExtQ;

   reg xOp0We;
   reg xOp1We;
   reg yOp0We;
   reg yOp1We;
   reg fbkWe;
   reg resLowWe;
   reg resMidWe;
   reg resExtWe;
   reg [15:0] yOp0D;
   reg [15:0] yOp1D;
   reg [15:0] fbkD;
   reg [15:0] resLowD;
   reg [15:0] resMidD;
   reg [7:0] resExtD;

   // ****************************************
   // Datapath signals
   // ****************************************
   reg [15:0] xOperand;
   reg [15:0] yOperand;
   reg [39:0] nxt_result;
   wire [16:0] xWide;
   wire [16:0] yWide;
   wire signed [33:0] fullProduct;
   wire [31:0] product;
   wire [39:0] alignedProduct;
   wire [39:0] accumNow;
   wire [15:0] resExtWide;
   wire accWrite;
   wire fbkWrite;
   wire nxt_overflow;
   reg [15:0] nxt_dmdRdData;
   reg [15:0] nxt_rBusData;

   assign accumNow = {resExtQ, resMidQ, resLowQ};

   assign resExtWide = {{`MAU_EXT_W{resExtQ[`MAU_EXT_W-1]}}, resExtQ};

   // ****************************************
   // Operand selection
   // ****************************************
   // X from file or result bus
   always @* begin
      if (xSel == `MAU_XS_XOP0) begin
         xOperand = xOp0Q;
      end else if (xSel == `MAU_XS_XOP1) begin
         xOperand = xOp1Q;
      end else if (xSel == `MAU_XS_ALU) begin
         xOperand = aluResult;
      end else if (xSel == `MAU_XS_RLOW) begin
         xOperand = resLowQ;
      end else if (xSel == `MAU_XS_RMID) begin
         xOperand = resMidQ;
      end else if (xSel == `MAU_XS_REXT) begin
         xOperand = resExtWide;
      end else if (xSel == `MAU_XS_SHL) begin
         xOperand = shifterResultLow;
      end else begin
         xOperand = shifterResultHigh;
      end
   end

   // Y from file or feedback
   // Unused code 3 falls back to the first Y register
   always @* begin
      if (ySel == `MAU_YS_YOP1) begin
         yOperand = yOp1Q;
      end else if (ySel == `MAU_YS_FBK) begin
         yOperand = fbkQ;
      end else begin
         yOperand = yOp0Q;
      end
   end

   // ****************************************
   // Multiplier and format alignment
   // ****************************************
   // per-instruction operand formats
   assign xWide = {xSigned & xOperand[15], xOperand};
   assign yWide = {ySigned & yOperand[15], yOperand};

   // 17-bit signed multiply, low 32 kept
   assign fullProduct = $signed(xWide) * $signed(yWide);
   assign product = fullProduct[`MAU_PROD_W-1:0];

   assign alignedProduct = {{7{product[31]}}, product, 1'b0};

   // ****************************************
   // Adder/subtractor
   // ****************************************
   // four functions
   always @* begin
      case (opFunc)
         `MAU_FN_MUL: begin
            nxt_result = alignedProduct;
         end
         `MAU_FN_ADD: begin
            nxt_result = accumNow + alignedProduct;
         end
         `MAU_FN_SUB: begin
            nxt_result = accumNow - alignedProduct;
         end
         default: begin
            nxt_result = {`MAU_ACC_W{1'b0}};
         end
      endcase
   end

   // top nine bits not all sign
   assign nxt_overflow = ~((&nxt_result[39:`MAU_OVF_LSB]) | ~(|nxt_result[39:`MAU_OVF_LSB]));

   // result goes to accumulator or feedback
   assign accWrite = opValid & (opDest == `MAU_DST_ACC);
   assign fbkWrite = opValid & (opDest == `MAU_DST_FBK);

   // ****************************************
   // Register write steering
   // ****************************************
   // X file written from data bus
   always @* begin
      xOp0We = dmdWrEn & (dmdWrSel == `MAU_RG_XOP0);
      xOp1We = dmdWrEn & (dmdWrSel == `MAU_RG_XOP1);
   end

   // Y file from data or program bus
   // Data bus wins if both aim at one register
   always @* begin
      yOp0We = 1'b0;
      yOp1We = 1'b0;
      yOp0D = dmdWrData;
      yOp1D = dmdWrData;
      if (dmdWrEn & (dmdWrSel == `MAU_RG_YOP0)) begin
         yOp0We = 1'b1;
      end else if (pmdWrEn & ~pmdWrSel) begin
         yOp0We = 1'b1;
         yOp0D = pmdWrData;
      end
      if (dmdWrEn & (dmdWrSel == `MAU_RG_YOP1)) begin
         yOp1We = 1'b1;
      end else if (pmdWrEn & pmdWrSel) begin
         yOp1We = 1'b1;
         yOp1D = pmdWrData;
      end
   end

   always @* begin
      fbkWe = 1'b0;
      fbkD = dmdWrData;
      if (fbkWrite) begin
         fbkWe = 1'b1;
         fbkD = nxt_result[`MAU_MID_MSB:`MAU_MID_LSB];
      end else if (dmdWrEn & (dmdWrSel == `MAU_RG_FBK)) begin
         fbkWe = 1'b1;
      end
   end

   // accumulator parts preloadable from data bus
   // A unit result beats a preload in the same cycle
   always @* begin
      resLowWe = 1'b0;
      resMidWe = 1'b0;
      resExtWe = 1'b0;
      resLowD = dmdWrData;
      resMidD = dmdWrData;
      resExtD = dmdWrData[`MAU_EXT_W-1:0];
      if (accWrite) begin
         resLowWe = 1'b1;
         resMidWe = 1'b1;
         resExtWe = 1'b1;
         resLowD = nxt_result[15:0];
         resMidD = nxt_result[`MAU_MID_MSB:`MAU_MID_LSB];
         resExtD = nxt_result[`MAU_EXT_MSB:`MAU_EXT_LSB];
      end else if (dmdWrEn & (dmdWrSel == `MAU_RG_RLOW)) begin
         resLowWe = 1'b1;
      end else if (dmdWrEn & (dmdWrSel == `MAU_RG_RMID)) begin
         resMidWe = 1'b1;
         resExtWe = 1'b1;
         resExtD = {`MAU_EXT_W{dmdWrData[15]}};
      end else if (dmdWrEn & (dmdWrSel == `MAU_RG_REXT)) begin
         resExtWe = 1'b1;
      end
   end

   // ****************************************
   // Banked registers
   // ****************************************
   // every register held in two banks
   // mode level is used as it stands, so a change
   // written by one instruction steers the next one
   // writes land at the clock edge ending the cycle
   mau_bank_reg #(.W(`MAU_DATA_W)) uXOp0 (
      .clk(core_clk), .nrst(nrst), .bankSel(bankSelect),
      .wrEn(xOp0We), .wrData(dmdWrData), .rdData(xOp0Q)
   );
   mau_bank_reg #(.W(`MAU_DATA_W)) uXOp1 (
      .clk(core_clk), .nrst(nrst), .bankSel(bankSelect),
      .wrEn(xOp1We), .wrData(dmdWrData), .rdData(xOp1Q)
   );
   mau_bank_reg #(.W(`MAU_DATA_W)) uYOp0 (
      .clk(core_clk), .nrst(nrst), .bankSel(bankSelect),
      .wrEn(yOp0We), .wrData(yOp0D), .rdData(yOp0Q)
   );
   mau_bank_reg #(.W(`MAU_DATA_W)) uYOp1 (
      .clk(core_clk), .nrst(nrst), .bankSel(bankSelect),
      .wrEn(yOp1We), .wrData(yOp1D), .rdData(yOp1Q)
   );
   mau_bank_reg #(.W(`MAU_DATA_W)) uFbk (
      .clk(core_clk), .nrst(nrst), .bankSel(bankSelect),
      .wrEn(fbkWe), .wrData(fbkD), .rdData(fbkQ)
   );
   mau_bank_reg #(.W(`MAU_DATA_W)) uResLow (
      .clk(core_clk), .nrst(nrst), .bankSel(bankSelect),
      .wrEn(resLowWe), .wrData(resLowD), .rdData(resLowQ)
   );
   mau_bank_reg #(.W(`MAU_DATA_W)) uResMid (
      .clk(core_clk), .nrst(nrst), .bankSel(bankSelect),
      .wrEn(resMidWe), .wrData(resMidD), .rdData(resMidQ)
   );
   mau_bank_reg #(.W(`MAU_EXT_W)) uResExt (
      .clk(core_clk), .nrst(nrst), .bankSel(bankSelect),
      .wrEn(resExtWe), .wrData(resExtD), .rdData(resExtQ)
   );

   // ****************************************
   // Data bus read
   // ****************************************
   // read port separate from operand path
   // no program-bus read port; Y reads leave
   // here and the exchange unit moves them across
   always @* begin
      if (dmdRdSel == `MAU_RG_XOP0) begin
         nxt_dmdRdData = xOp0Q;
      end else if (dmdRdSel == `MAU_RG_XOP1) begin
         nxt_dmdRdData = xOp1Q;
      end else if (dmdRdSel == `MAU_RG_YOP0) begin
         nxt_dmdRdData = yOp0Q;
      end else if (dmdRdSel == `MAU_RG_YOP1) begin
         nxt_dmdRdData = yOp1Q;
      end else if (dmdRdSel == `MAU_RG_FBK) begin
         nxt_dmdRdData = fbkQ;
      end else if (dmdRdSel == `MAU_RG_RLOW) begin
         nxt_dmdRdData = resLowQ;
      end else if (dmdRdSel == `MAU_RG_RMID) begin
         nxt_dmdRdData = resMidQ;
      end else begin
         nxt_dmdRdData = resExtWide;
      end
   end

   // accumulator parts onto the result bus
   always @* begin
      if (rBusSel == `MAU_RB_RLOW) begin
         nxt_rBusData = resLowQ;
      end else if (rBusSel == `MAU_RB_RMID) begin
         nxt_rBusData = resMidQ;
      end else if (rBusSel == `MAU_RB_REXT) begin
         nxt_rBusData = resExtWide;
      end else begin
         nxt_rBusData = `MAU_RST_DATA;
      end
   end

   // ****************************************
   // Output registers
   // ****************************************
   // captured values are pre-write contents
   // Bus data hold their last value between reads
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         dmdRdData_ff <= `MAU_RST_DATA;
         rBusData_ff <= `MAU_RST_DATA;
      end else begin
         if (dmdRdEn) begin
            dmdRdData_ff <= nxt_dmdRdData;
         end
         if (rBusRdEn) begin
            rBusData_ff <= nxt_rBusData;
         end
      end
   end

   // flag refreshed on every operation
   // An operation beats a status write in the same cycle
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         accumOverflow_ff <= `MAU_RST_FLAG;
      end else if (opValid) begin
         accumOverflow_ff <= nxt_overflow;
      end else if (statusWrEn) begin
         accumOverflow_ff <= statusWrData;
      end
   end

endmodule

`default_nettype wire

//--- core/mau_defs.vh
// Constants for the multiply/accumulate unit: widths, selector codes,
// function codes and reset values.
// Assumes inclusion by bare name from the design files of the unit.
//
// Operation
// - Two 16-bit operands give 32-bit product
// - Product added to or subtracted from accumulator
// - Accumulator: low 16, middle 16, extension 8
// - Overflow when top nine bits disagree
// - X from operand registers or result bus
// - X registers on data bus, dual-ported
// - Y from operand registers or feedback
// - Y program-bus reads go through exchange
// - Result to accumulator or feedback bits 16-31
// - Accumulator parts loaded and driven on buses
// - Read at cycle start, written at end
// - Two banks, only one accessible
// - Mode bit selects active bank
// - Multiply, add, subtract and clear functions
// - Product sign-extended and shifted left once
// - Alignment applies for every operand format
// - Per-instruction signed or unsigned X, Y
// - Extension part sign-extended onto buses
// - Middle load sign-fills extension part
// - Overflow flag updated every operation
`ifndef MAU_DEFS_VH
`define MAU_DEFS_VH

// ****************************************
// Widths and field positions
// ****************************************
`define MAU_DATA_W 16
`define MAU_EXT_W 8
`define MAU_ACC_W 40
`define MAU_PROD_W 32
`define MAU_MID_LSB 16
`define MAU_MID_MSB 31
`define MAU_EXT_LSB 32
`define MAU_EXT_MSB 39
`define MAU_OVF_LSB 31

// ****************************************
// Function codes
// ****************************************
`define MAU_FN_MUL 2'h0
`define MAU_FN_ADD 2'h1
`define MAU_FN_SUB 2'h2
`define MAU_FN_CLR 2'h3

// ****************************************
// X operand source codes
// ****************************************
`define MAU_XS_XOP0 3'h0
`define MAU_XS_XOP1 3'h1
`define MAU_XS_ALU 3'h2
`define MAU_XS_RLOW 3'h3
`define MAU_XS_RMID 3'h4
`define MAU_XS_REXT 3'h5
`define MAU_XS_SHL 3'h6
`define MAU_XS_SHH 3'h7

// ****************************************
// Y operand source codes
// ****************************************
`define MAU_YS_YOP0 2'h0
`define MAU_YS_YOP1 2'h1
`define MAU_YS_FBK 2'h2

// ****************************************
// Destination codes
// ****************************************
`define MAU_DST_ACC 1'h0
`define MAU_DST_FBK 1'h1

// ****************************************
// Register codes on the data bus
// ****************************************
`define MAU_RG_XOP0 3'h0
`define MAU_RG_XOP1 3'h1
`define MAU_RG_YOP0 3'h2
`define MAU_RG_YOP1 3'h3
`define MAU_RG_FBK 3'h4
`define MAU_RG_RLOW 3'h5
`define MAU_RG_RMID 3'h6
`define MAU_RG_REXT 3'h7

// ****************************************
// Result bus part codes
// ****************************************
`define MAU_RB_RLOW 2'h0
`define MAU_RB_RMID 2'h1
`define MAU_RB_REXT 2'h2

// ****************************************
// Reset values
// ****************************************
`define MAU_RST_DATA 16'h0000
`define MAU_RST_EXT 8'h00
`define MAU_RST_FLAG 1'h0

`endif

//--- verification/mau_core_monitor.sv
// Checker for the multiply/accumulate unit, watching top-level ports only.
// Assumes one clock domain and an asynchronous active-low reset.
`default_nettype none

module mau_monitor (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic bankSelect,
   input wire logic opValid,
   input wire logic [1:0] opFunc,
   input wire logic dmdWrEn,
   input wire logic [2:0] dmdWrSel,
   input wire logic [15:0] dmdWrData,
   input wire logic dmdRdEn,
   input wire logic [2:0] dmdRdSel,
   input wire logic rBusRdEn,
   input wire logic [1:0] rBusSel,
   input wire logic statusWrEn,
   input wire logic statusWrData,
   input wire logic [15:0] dmdRdData_ff,
   input wire logic [15:0] rBusData_ff,
   input wire logic accumOverflow_ff
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);

   // ****************************************
   // Overflow flag
   // ****************************************
   property p_clearNoOvf;
      opValid && opFunc == 2'h3 |=> !accumOverflow_ff;
   endproperty
   a_clearNoOvf: assert property (p_clearNoOvf) else $error("flag set after clear");
   property p_ovfHold;
      !opValid && !statusWrEn |=> $stable(accumOverflow_ff);
   endproperty
   a_ovfHold: assert property (p_ovfHold) else $error("flag moved without cause");
   property p_statusWr;
      !opValid && statusWrEn |=> accumOverflow_ff == $past(statusWrData);
   endproperty
   a_statusWr: assert property (p_statusWr) else $error("flag write lost");

   // ****************************************
   // Register reads
   // ****************************************
   property p_extDmd;
      dmdRdEn && dmdRdSel == 3'h7 |=> dmdRdData_ff[15:8] == {8{dmdRdData_ff[7]}};
   endproperty
   a_extDmd: assert property (p_extDmd) else $error("extension not sign-filled");
   property p_extRbus;
      rBusRdEn && rBusSel == 2'h2 |=> rBusData_ff[15:8] == {8{rBusData_ff[7]}};
   endproperty
   a_extRbus: assert property (p_extRbus) else $error("extension not sign-filled");
   property p_dmdHold;
      !dmdRdEn |=> $stable(dmdRdData_ff);
   endproperty
   a_dmdHold: assert property (p_dmdHold) else $error("data read moved");
   property p_rbusHold;
      !rBusRdEn |=> $stable(rBusData_ff);
   endproperty
   a_rbusHold: assert property (p_rbusHold) else $error("result read moved");
   // Write shows only from the next cycle on
   property p_xWriteRead;
      dmdWrEn && dmdWrSel == 3'h0 ##1 dmdRdEn && dmdRdSel == 3'h0 && $stable(bankSelect)
         |=> dmdRdData_ff == $past(dmdWrData, 2);
   endproperty
   a_xWriteRead: assert property (p_xWriteRead) else $error("operand write lost");
   property p_midFill;
      dmdWrEn && dmdWrSel == 3'h6 && !opValid ##1 dmdRdEn && dmdRdSel == 3'h7 && $stable(bankSelect)
         |=> dmdRdData_ff == {16{$past(dmdWrData[15], 2)}};
   endproperty
   a_midFill: assert property (p_midFill) else $error("middle load no sign fill");
endmodule

bind mau_core mau_monitor u_mon (.core_clk, .nrst, .bankSelect, .opValid, .opFunc, .dmdWrEn, .dmdWrSel,
   .dmdWrData, .dmdRdEn, .dmdRdSel, .rBusRdEn, .rBusSel, .statusWrEn, .statusWrData, .dmdRdData_ff,
   .rBusData_ff, .accumOverflow_ff);
`default_nettype wire

//--- verification/mau_rbus_src.sv
// Stand-in for the other computational units on the shared result bus.
// Assumes they refresh their result registers on every rising edge.
`default_nettype none

module mau_rbus_src (
   input wire logic core_clk,
   input wire logic nrst,
   output var logic [15:0] aluResult,
   output var logic [15:0] shifterResultLow,
   output var logic [15:0] shifterResultHigh
);
   timeunit 1ns;
   timeprecision 1ps;
   // New values every cycle, so a stale operand gives a mismatch
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         aluResult <= 16'h8001;
         shifterResultLow <= 16'h7FFE;
         shifterResultHigh <= 16'hF00F;
      end else begin
         aluResult <= aluResult * 16'h6255 + 16'h3619;
         shifterResultLow <= shifterResultLow * 16'h4E6D + 16'h0B0B;
         shifterResultHigh <= {shifterResultHigh[14:0], ~shifterResultHigh[15]};
      end
   end
endmodule
`default_nettype wire

//--- verification/tb_multiply_accumulate_unit.sv
// Random testbench for the multiply/accumulate unit against an integer model.
// Assumes outputs are registered and read a cycle after the request.
`default_nettype none

module tb_multiply_accumulate_unit;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0, nrst = 1'b0, bankSelect = 1'b0, opValid = 1'b0, xSigned = 1'b0, ySigned = 1'b0;
   logic opDest = 1'b0, dmdWrEn = 1'b0, dmdRdEn = 1'b0, pmdWrEn = 1'b0, pmdWrSel = 1'b0, rBusRdEn = 1'b0;
   logic statusWrEn = 1'b0, statusWrData = 1'b0;
   logic [1:0] opFunc = 2'h0, ySel = 2'h0, rBusSel = 2'h0;
   logic [2:0] xSel = 3'h0, dmdWrSel = 3'h0, dmdRdSel = 3'h0;
   logic [15:0] dmdWrData = 16'h0000, pmdWrData = 16'h0000;
   logic [15:0] aluResult, shifterResultLow, shifterResultHigh, dmdRdData_ff, rBusData_ff;
   logic accumOverflow_ff;
   logic [31:0] seed = 32'hA39E;
   longint acc[2];
   int xr[2][2], yr[2][2], fb[2], ovf, expD, expR, fails, checked;

   mau_rbus_src u_src (.core_clk, .nrst, .aluResult, .shifterResultLow, .shifterResultHigh);
   mau_core DUT (.core_clk, .nrst, .bankSelect, .opValid, .opFunc, .xSigned, .ySigned, .xSel, .ySel, .opDest,
      .aluResult, .shifterResultLow, .shifterResultHigh, .dmdWrEn, .dmdWrSel, .dmdWrData, .dmdRdEn, .dmdRdSel,
      .pmdWrEn, .pmdWrSel, .pmdWrData, .rBusRdEn, .rBusSel, .statusWrEn, .statusWrData, .dmdRdData_ff,
      .rBusData_ff, .accumOverflow_ff);

   // 20 MHz core clock
   always #25 core_clk = ~core_clk;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic int rdReg(int b, int s);
      case (s)
         0, 1: return xr[b][s];
         2, 3: return yr[b][s - 2];
         4: return fb[b];
         5: return int'(acc[b] & 64'hFFFF);
         6: return int'(acc[b] >> 16 & 64'hFFFF);
         default: return int'(acc[b] >> 32) | (acc[b][39] ? 32'hFF00 : 32'h0);
      endcase
   endfunction

   task automatic cmp(logic [15:0] e, logic [15:0] g);
      checked++;
      if (g !== e) begin
         fails++;
         $display("unexpected at %0t: expected %h got %h", $time, e, g);
      end
   endtask

   task automatic check();
      cmp(expD[15:0], dmdRdData_ff);
      cmp(expR[15:0], rBusData_ff);
      cmp(ovf[15:0], {15'h0, accumOverflow_ff});
   endtask

   // ****************************************
   // One random instruction and model step
   // ****************************************
   task automatic step();
      logic [31:0] r;
      logic [31:0] d;
      int b;
      int xv;
      int yv;
      int w;
      longint res;
      longint t;
      r = rnd();
      d = rnd();
      if (r[31:29] == 3'h0) bankSelect = ~bankSelect;
      {statusWrData, statusWrEn, rBusSel, rBusRdEn, pmdWrSel, pmdWrEn, dmdRdSel, dmdRdEn, dmdWrSel, dmdWrEn,
         opDest, ySel, xSel, ySigned, xSigned, opFunc, opValid} = r[25:0];
      {dmdWrData, pmdWrData} = d;
      b = bankSelect;
      w = dmdWrData;
      case (xSel)
         3'h2: xv = aluResult;
         3'h6: xv = shifterResultLow;
         3'h7: xv = shifterResultHigh;
         default: xv = xSel < 3'h2 ? xr[b][xSel[0]] : rdReg(b, xSel + 2);
      endcase
      yv = ySel == 2'h2 ? fb[b] : yr[b][ySel == 2'h1];
      if (xSigned && xv[15]) xv -= 32'h10000;
      if (ySigned && yv[15]) yv -= 32'h10000;
      // aligned product: low 32 bits kept, sign-extended
      // Full 64-bit multiply first, so no int wrap decides the upper bits
      res = longint'(xv) * longint'(yv);
      res = {{32{res[31]}}, res[31:0]} <<< 1;
      case (opFunc)
         2'h1: res = acc[b] + res;
         2'h2: res = acc[b] - res;
         2'h3: res = 0;
         default: ;
      endcase
      res &= 64'hFF_FFFF_FFFF;
      t = res >> 31;
      if (dmdRdEn) expD = rdReg(b, dmdRdSel);
      if (rBusRdEn) expR = rBusSel == 2'h3 ? 0 : rdReg(b, rBusSel + 5);
      if (pmdWrEn) yr[b][pmdWrSel] = pmdWrData;
      if (dmdWrEn) begin
         case (dmdWrSel)
            3'h0, 3'h1: xr[b][dmdWrSel[0]] = w;
            3'h2, 3'h3: yr[b][dmdWrSel[0]] = w;
            3'h4: fb[b] = w;
            3'h5: acc[b] = acc[b] & 64'hFF_FFFF_0000 | w;
            3'h6: acc[b] = acc[b] & 64'hFFFF | longint'(w) << 16 | (w[15] ? 64'hFF_0000_0000 : 0);
            default: acc[b] = acc[b] & 64'hFFFF_FFFF | longint'(w & 32'hFF) << 32;
         endcase
      end
      if (opValid) begin
         if (opDest) begin
            fb[b] = int'(res >> 16 & 64'hFFFF);
         end else begin
            acc[b] = res;
         end
         ovf = t != 0 && t != 64'h1FF;
      end else if (statusWrEn) begin
         ovf = statusWrData;
      end
   endtask

   task automatic test_done();
      if (fails == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Reset, then a long random instruction stream checked each cycle
   initial begin
      repeat (16) @(negedge core_clk);
      nrst = 1'b1;
      repeat (4000) begin
         @(negedge core_clk);
         check();
         step();
      end
      @(negedge core_clk);
      check();
      test_done();
   end
endmodule
`default_nettype wire
